// File: pwm_pkg.sv
// constants, register map and field layout of the async pwm timer slice
// assumes a word-addressed avalon slave: index n sits at byte 4*n
// ============================================================
// Contract
// - software strobe captures counter into capture_value
// - command_ready_flag drops while capture is pending
// - one event both captures and steers counter
// - fault_control zero at reset, then fuse loaded
// - enable bits gate outputs, fault values on fault
// - output_override drives outputs from state values
// - one ramp: each output uses own states
// - input event forces outputs to fault value
// - four output events, three matches plus programmable
// - match events are one-cycle strobes
// - programmable event is one-cycle strobe
// - blanking trigger shared, blanking event not delayed
// - trigger select 2 delays event by delay_value
// - delay ticks from synchronizer clock prescaler
// - cycle_done_irq set at end of cycle
// - on-time entry flags set on entering on-times
// - request active while flag and enable set
// - both trigger flags ored into one request
// - runs in idle, stops in standby and power-down
// - fault_control write needs key within four cycles
// - event capture action bit enables event capture
package pwm_pkg;
  // ============================================================
  // register indices
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_CTRL_C = 6'h02;
  localparam logic [5:0] IDX_CTRL_D = 6'h03;
  localparam logic [5:0] IDX_CMD = 6'h04;
  localparam logic [5:0] IDX_EV_A = 6'h08;
  localparam logic [5:0] IDX_EV_B = 6'h09;
  localparam logic [5:0] IDX_IRQ_EN = 6'h0c;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h0d;
  localparam logic [5:0] IDX_STATUS = 6'h0e;
  localparam logic [5:0] IDX_IN_A = 6'h10;
  localparam logic [5:0] IDX_IN_B = 6'h11;
  localparam logic [5:0] IDX_FAULT = 6'h12;
  localparam logic [5:0] IDX_DLY_CTRL = 6'h14;
  localparam logic [5:0] IDX_DLY_VAL = 6'h15;
  localparam logic [5:0] IDX_CAP_A = 6'h22;
  localparam logic [5:0] IDX_CAP_B = 6'h24;
  localparam logic [5:0] IDX_ASET = 6'h28;
  localparam logic [5:0] IDX_ACLR = 6'h2a;
  localparam logic [5:0] IDX_BSET = 6'h2c;
  localparam logic [5:0] IDX_BCLR = 6'h2e;
  localparam logic [5:0] IDX_PROTECT = 6'h30;
  // ============================================================
  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_OVERRIDE = 0;
  localparam int BIT_SCAP_A = 2;
  localparam int BIT_ACTION = 2;
  localparam int BIT_OVF = 0;
  localparam int BIT_TRIG_A = 2;
  localparam int BIT_TRIG_B = 3;
  localparam int BIT_CMD_READY = 1;
  localparam int BIT_FAULT_EN_A = 4;
  // ============================================================
  // values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] IO_REGISTER_KEY = 8'h9d; // arbitrary value
  localparam logic [2:0] KEY_WINDOW_CYC = 3'h4;
  localparam logic [1:0] CAP_SYNC_CYC = 2'h2;
  localparam logic [3:0] MODE_RESTART = 4'h8;
  localparam logic [1:0] TRIG_OFF = 2'h0;
  localparam logic [1:0] TRIG_BLANK = 2'h1;
  localparam logic [1:0] TRIG_DELAYED = 2'h2;
  localparam logic [1:0] SLEEP_STANDBY = 2'h2;
  typedef enum logic [0:0] {DLY_IDLE = 1'b0, DLY_COUNT = 1'b1} dly_state_e;
endpackage

// File: pwm_timer_capture_output_events.sv
// counter, capture, output control, events and flags of the pwm timer
// single clock; registers over avalon-mm, answered one cycle after request
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module pwm_timer_capture_output_events #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // avalon-mm slave
  input wire logic [5:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // system
  input wire logic [7:0] FUSE_CFG,
  input wire logic [1:0] SLEEP_MODE,
  input wire logic EV_IN_A,
  input wire logic EV_IN_B,
  // pins and events
  output logic WO_A,
  output logic WO_B,
  output logic EV_COMPARE_B_CLEAR,
  output logic EV_COMPARE_A_SET,
  output logic EV_COMPARE_B_SET,
  output logic EV_PROG,
  output logic IRQ_OVF,
  output logic IRQ_TRIG
);
  // ============================================================
  // bus slave
  logic ack;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  assign req = READ | WRITE;
  assign WAITREQUEST = req & ~ack;
  assign wr = WRITE & ack;
  assign rd = READ & ~ack;
  assign wbyte = WRITEDATA[7:0];

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      ack <= 1'b0;
    else
      ack <= req & ~ack;

  // ============================================================
  // registers
  logic [7:0] ctrl_a, ctrl_c, ctrl_d, irq_en, irq_flag, fault_ctrl;
  logic [7:0] dly_ctrl, dly_val;
  logic [7:0] ev_ctrl [2];
  logic [3:0] in_ctrl [2];
  logic [CNT_W-1:0] aset, aclr, bset, bclr;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] capture [2];
  logic [7:0] cap_hi [2];
  logic fuse_pending;
  logic [2:0] key_cnt;
  logic [15:0] wide_w;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      ctrl_a <= pwm_pkg::RST_BYTE;
      ctrl_c <= pwm_pkg::RST_BYTE;
      ctrl_d <= pwm_pkg::RST_BYTE;
      irq_en <= pwm_pkg::RST_BYTE;
      dly_ctrl <= pwm_pkg::RST_BYTE;
      dly_val <= pwm_pkg::RST_BYTE;
      ev_ctrl[0] <= pwm_pkg::RST_BYTE;
      ev_ctrl[1] <= pwm_pkg::RST_BYTE;
      in_ctrl[0] <= 4'h0;
      in_ctrl[1] <= 4'h0;
    end
    else if (wr)
    begin
      if (ADDRESS == pwm_pkg::IDX_CTRL_A)
        ctrl_a <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_CTRL_C)
        ctrl_c <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_CTRL_D)
        ctrl_d <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_IRQ_EN)
        irq_en <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_DLY_CTRL)
        dly_ctrl <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_DLY_VAL)
        dly_val <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_EV_A)
        ev_ctrl[0] <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_EV_B)
        ev_ctrl[1] <= wbyte;
      else if (ADDRESS == pwm_pkg::IDX_IN_A)
        in_ctrl[0] <= wbyte[3:0];
      else if (ADDRESS == pwm_pkg::IDX_IN_B)
        in_ctrl[1] <= wbyte[3:0];
    end

  // compare bytes are written low and high separately, no staging
  assign wide_w = {wbyte, wbyte};
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      aset <= '0;
      aclr <= '0;
      bset <= '0;
      bclr <= '0;
    end
    else if (wr)
    begin
      if (ADDRESS[5:1] == pwm_pkg::IDX_ASET[5:1])
        aset <= set_byte(aset, ADDRESS[0]);
      else if (ADDRESS[5:1] == pwm_pkg::IDX_ACLR[5:1])
        aclr <= set_byte(aclr, ADDRESS[0]);
      else if (ADDRESS[5:1] == pwm_pkg::IDX_BSET[5:1])
        bset <= set_byte(bset, ADDRESS[0]);
      else if (ADDRESS[5:1] == pwm_pkg::IDX_BCLR[5:1])
        bclr <= set_byte(bclr, ADDRESS[0]);
    end

  function automatic logic [CNT_W-1:0] set_byte(
    input logic [CNT_W-1:0] old, input logic hi);
    logic [15:0] v;
    v = 16'(old);
    if (hi)
      v[15:8] = wide_w[15:8];
    else
      v[7:0] = wide_w[7:0];
    return v[CNT_W-1:0];
  endfunction

  // ============================================================
  // protected fault control
  logic key_ok;
  assign key_ok = key_cnt != 3'h0;
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      key_cnt <= 3'h0;
    else if (wr && ADDRESS == pwm_pkg::IDX_PROTECT
             && wbyte == pwm_pkg::IO_REGISTER_KEY)
      key_cnt <= pwm_pkg::KEY_WINDOW_CYC;
    else if (key_ok)
      key_cnt <= key_cnt - 3'h1;

  // reset clears it, the fuse byte is taken at the first edge after
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      fault_ctrl <= pwm_pkg::RST_BYTE;
      fuse_pending <= 1'b1;
    end
    else if (fuse_pending)
    begin
      fault_ctrl <= FUSE_CFG;
      fuse_pending <= 1'b0;
    end
    else if (wr && ADDRESS == pwm_pkg::IDX_FAULT && key_ok)
      fault_ctrl <= wbyte;

  // ============================================================
  // counter, one ramp
  logic run, cyc_end;
  logic [1:0] ev_in, restart, fault_now, wave, ovr_out;
  logic [1:0] fault_hold;
  assign ev_in = {EV_IN_B, EV_IN_A};
  assign run = ctrl_a[pwm_pkg::BIT_ENABLE]
               && SLEEP_MODE < pwm_pkg::SLEEP_STANDBY;
  assign cyc_end = run && cnt >= bclr;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      cnt <= '0;
    else if (run)
    begin
      if (cyc_end || restart != 2'b00)
        cnt <= '0;
      else
        cnt <= cnt + CNT_W'(1);
    end

  // ============================================================
  // per channel: capture, input mode, fault and output
  logic [1:0] sync_cnt;
  logic [1:0] sw_pend;
  logic cmd_ready;
  logic st_on_a, st_on_b;
  assign st_on_a = cnt >= aset && cnt < aclr;
  assign st_on_b = cnt >= bset && cnt <= bclr;
  assign wave = {st_on_b, st_on_a};
  // bit0 dead a, bit1 on a, bit6 dead b, bit7 on b
  assign ovr_out[0] = st_on_a ? ctrl_d[1] : ctrl_d[0];
  assign ovr_out[1] = st_on_b ? ctrl_d[7] : ctrl_d[6];
  assign cmd_ready = sync_cnt == 2'h0;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      sync_cnt <= 2'h0;
      sw_pend <= 2'b00;
    end
    else if (wr && ADDRESS == pwm_pkg::IDX_CMD
             && wbyte[pwm_pkg::BIT_SCAP_A+:2] != 2'b00)
    begin
      sw_pend <= sw_pend | wbyte[pwm_pkg::BIT_SCAP_A+:2];
      sync_cnt <= pwm_pkg::CAP_SYNC_CYC;
    end
    else if (!cmd_ready)
    begin
      sync_cnt <= sync_cnt - 2'h1;
      if (sync_cnt == 2'h1)
        sw_pend <= 2'b00;
    end

  logic [1:0] outs;
  genvar i;
  for (i = 0; i < 2; i++)
  begin : g_ch
    logic load;
    assign load = (ev_in[i] && ev_ctrl[i][pwm_pkg::BIT_ACTION])
                  || (sw_pend[i] && sync_cnt == 2'h1);
    assign restart[i] = run && ev_in[i]
                        && in_ctrl[i] == pwm_pkg::MODE_RESTART;
    assign fault_now[i] = ev_in[i] && in_ctrl[i] != 4'h0;

    always_ff @(posedge CLK or negedge RESET_N)
      if (!RESET_N)
        capture[i] <= '0;
      else if (load)
        capture[i] <= cnt;

    // reading the low byte freezes the high byte for the next read
    always_ff @(posedge CLK or negedge RESET_N)
      if (!RESET_N)
        cap_hi[i] <= 8'h00;
      else if (rd && ADDRESS == pwm_pkg::IDX_CAP_A + 6'(2 * i))
        cap_hi[i] <= 8'(capture[i] >> 8);

    // a fault holds its level until the cycle ends
    always_ff @(posedge CLK or negedge RESET_N)
      if (!RESET_N)
        fault_hold[i] <= 1'b0;
      else if (fault_now[i])
        fault_hold[i] <= 1'b1;
      else if (cyc_end)
        fault_hold[i] <= 1'b0;

    // event path stays combinational so a fault reaches the pin at once
    assign outs[i] = fault_ctrl[pwm_pkg::BIT_FAULT_EN_A + i]
      & ((fault_now[i] | fault_hold[i]) ? fault_ctrl[i]
      : (ctrl_c[pwm_pkg::BIT_OVERRIDE] ? ovr_out[i] : wave[i]));
  end

  assign WO_A = outs[0];
  assign WO_B = outs[1];

  // ============================================================
  // flags and requests
  logic [7:0] flag_set, flag_clr;
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[pwm_pkg::BIT_OVF] = cyc_end;
    flag_set[pwm_pkg::BIT_TRIG_A] = run && cnt == aset;
    flag_set[pwm_pkg::BIT_TRIG_B] = run && cnt == bset;
    flag_clr = (wr && ADDRESS == pwm_pkg::IDX_IRQ_FLAG) ? wbyte : 8'h00;
  end

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      irq_flag <= pwm_pkg::RST_BYTE;
    else
      irq_flag <= (irq_flag & ~flag_clr) | flag_set;

  assign IRQ_OVF = irq_flag[pwm_pkg::BIT_OVF]
                   & irq_en[pwm_pkg::BIT_OVF];
  assign IRQ_TRIG = |(irq_flag[pwm_pkg::BIT_TRIG_B:pwm_pkg::BIT_TRIG_A]
                   & irq_en[pwm_pkg::BIT_TRIG_B:pwm_pkg::BIT_TRIG_A]);

  // ============================================================
  // output events
  logic [3:0] match;
  assign match = {run && cnt == aclr, run && cnt == bset,
                  run && cnt == aset, cyc_end};
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      EV_COMPARE_B_CLEAR <= 1'b0;
      EV_COMPARE_A_SET <= 1'b0;
      EV_COMPARE_B_SET <= 1'b0;
    end
    else
    begin
      EV_COMPARE_B_CLEAR <= match[0];
      EV_COMPARE_A_SET <= match[1];
      EV_COMPARE_B_SET <= match[2];
    end

  // trigger and delay are shared with blanking, so blanking never delays
  pwm_pkg::dly_state_e dly_state;
  logic [1:0] trig_mode;
  logic trig, tick;
  logic [2:0] pre_cnt, pre_mask;
  logic [7:0] dcnt;
  assign trig_mode = dly_ctrl[3:2];
  assign trig = match[dly_ctrl[1:0]];
  assign pre_mask = 3'((4'h1 << dly_ctrl[5:4]) - 4'h1);
  assign tick = (pre_cnt & pre_mask) == pre_mask;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      pre_cnt <= 3'h0;
    else if (dly_state == pwm_pkg::DLY_COUNT)
      pre_cnt <= pre_cnt + 3'h1;
    else
      pre_cnt <= 3'h0;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      dly_state <= pwm_pkg::DLY_IDLE;
      dcnt <= 8'h00;
      EV_PROG <= 1'b0;
    end
    else
    begin
      EV_PROG <= 1'b0;
      case (dly_state)
        pwm_pkg::DLY_IDLE:
          if (trig && trig_mode != pwm_pkg::TRIG_OFF)
          begin
            if (trig_mode != pwm_pkg::TRIG_DELAYED || dly_val == 8'h00)
              EV_PROG <= 1'b1;
            else
            begin
              dly_state <= pwm_pkg::DLY_COUNT;
              dcnt <= 8'h00;
            end
          end
        pwm_pkg::DLY_COUNT:
          if (tick)
          begin
            dcnt <= dcnt + 8'h01;
            if (dcnt + 8'h01 == dly_val)
            begin
              EV_PROG <= 1'b1;
              dly_state <= pwm_pkg::DLY_IDLE;
            end
          end
        default:
          dly_state <= pwm_pkg::DLY_IDLE;
      endcase
    end

  // ============================================================
  // read mux, unmapped reads as zero
  logic [7:0] rbyte;
  always_comb
  begin
    rbyte = 8'h00;
    if (ADDRESS == pwm_pkg::IDX_CTRL_A)
      rbyte = ctrl_a;
    else if (ADDRESS == pwm_pkg::IDX_CTRL_C)
      rbyte = ctrl_c;
    else if (ADDRESS == pwm_pkg::IDX_CTRL_D)
      rbyte = ctrl_d;
    else if (ADDRESS == pwm_pkg::IDX_EV_A)
      rbyte = ev_ctrl[0];
    else if (ADDRESS == pwm_pkg::IDX_EV_B)
      rbyte = ev_ctrl[1];
    else if (ADDRESS == pwm_pkg::IDX_IRQ_EN)
      rbyte = irq_en;
    else if (ADDRESS == pwm_pkg::IDX_IRQ_FLAG)
      rbyte = irq_flag;
    else if (ADDRESS == pwm_pkg::IDX_STATUS)
      rbyte = 8'(cmd_ready) << pwm_pkg::BIT_CMD_READY;
    else if (ADDRESS == pwm_pkg::IDX_IN_A)
      rbyte = 8'(in_ctrl[0]);
    else if (ADDRESS == pwm_pkg::IDX_IN_B)
      rbyte = 8'(in_ctrl[1]);
    else if (ADDRESS == pwm_pkg::IDX_FAULT)
      rbyte = fault_ctrl;
    else if (ADDRESS == pwm_pkg::IDX_DLY_CTRL)
      rbyte = dly_ctrl;
    else if (ADDRESS == pwm_pkg::IDX_DLY_VAL)
      rbyte = dly_val;
    else if (ADDRESS == pwm_pkg::IDX_CAP_A)
      rbyte = capture[0][7:0];
    else if (ADDRESS == pwm_pkg::IDX_CAP_A + 6'h01)
      rbyte = cap_hi[0];
    else if (ADDRESS == pwm_pkg::IDX_CAP_B)
      rbyte = capture[1][7:0];
    else if (ADDRESS == pwm_pkg::IDX_CAP_B + 6'h01)
      rbyte = cap_hi[1];
  end

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      READDATA <= 32'h0;
    else if (rd)
      READDATA <= 32'(rbyte);

  // ============================================================
  // assertions
  AST_CMD_DROP: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr && ADDRESS == pwm_pkg::IDX_CMD && wbyte[3:2] != 2'b00
    |=> !cmd_ready ##1 !cmd_ready ##1 cmd_ready)
    else $error("command ready not dropped for two cycles");
  AST_SW_CAPTURE: assert property (@(posedge CLK) disable iff (!RESET_N)
    sw_pend[0] && sync_cnt == 2'h1 && !ev_in[0]
    |=> capture[0] == $past(cnt))
    else $error("software capture value wrong");
  AST_RESTART: assert property (@(posedge CLK) disable iff (!RESET_N)
    restart[1] |=> cnt == '0)
    else $error("restart mode did not clear counter");
  AST_FUSE_LOAD: assert property (@(posedge CLK) disable iff (!RESET_N)
    fuse_pending |=> fault_ctrl == $past(FUSE_CFG) && !fuse_pending)
    else $error("fuse byte not loaded");
  AST_FAULT_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
    fault_now[0] |-> WO_A == (fault_ctrl[4] & fault_ctrl[0]))
    else $error("fault did not force output a");
  AST_OVERRIDE_B: assert property (@(posedge CLK) disable iff (!RESET_N)
    ctrl_c[0] && fault_ctrl[5] && !fault_now[1] && !fault_hold[1]
    |-> WO_B == (st_on_b ? ctrl_d[7] : ctrl_d[6]))
    else $error("override level wrong on output b");
  AST_MATCH_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N)
    EV_COMPARE_B_CLEAR && bclr != '0 && $stable(bclr) |=> !EV_COMPARE_B_CLEAR)
    else $error("match strobe longer than one cycle");
  AST_DELAY_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
    dly_state == pwm_pkg::DLY_IDLE && trig && trig_mode == 2'h2
    && dly_val == 8'h02 && dly_ctrl[5:4] == 2'h0 && $stable(dly_ctrl)
    |=> !EV_PROG ##1 !EV_PROG ##1 EV_PROG)
    else $error("delayed event wrong cycle");
  AST_KEY_GUARD: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr && ADDRESS == pwm_pkg::IDX_FAULT && !key_ok && !fuse_pending
    |=> $stable(fault_ctrl))
    else $error("unprotected write changed fault control");
  AST_SLEEP_STOP: assert property (@(posedge CLK) disable iff (!RESET_N)
    SLEEP_MODE >= 2'h2 |=> $stable(cnt))
    else $error("counter ran in deep sleep");
  AST_IRQ_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
    IRQ_OVF && !(wr && (ADDRESS == pwm_pkg::IDX_IRQ_FLAG
    || ADDRESS == pwm_pkg::IDX_IRQ_EN)) |=> IRQ_OVF)
    else $error("request dropped without clear");
  AST_OVF_SET: assert property (@(posedge CLK) disable iff (!RESET_N)
    cyc_end |=> irq_flag[0])
    else $error("cycle done flag not set");
  COV_SW_CAPTURE: cover property (@(posedge CLK) $rose(cmd_ready));
  COV_DELAYED: cover property (@(posedge CLK) EV_PROG && trig_mode == 2'h2);
  COV_FAULT: cover property (@(posedge CLK) fault_now[1] && WO_B);
endmodule // pwm_timer_capture_output_events

// File: pwm_ev_partner.sv
// event system and strobe watcher facing the pwm timer slice
// assumes fire requests are levels set by the bench at rising edges
`timescale 1ns/10ps
module pwm_ev_partner (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // requests from the bench
  input wire logic [1:0] fire,
  // timer side
  input wire logic [3:0] strobes,
  output logic ev_a,
  output logic ev_b,
  output logic [3:0] seen,
  output logic wide
);
  // ============================================================
  // input event pulses
  // a held request yields one pulse only, as a real channel would
  logic [1:0] fire_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fire_q <= 2'h0;
      ev_a <= 1'b0;
      ev_b <= 1'b0;
    end
    else
    begin
      fire_q <= fire;
      ev_a <= fire[0] & ~fire_q[0];
      ev_b <= fire[1] & ~fire_q[1];
    end
  end
  // ============================================================
  // strobe watcher
  logic [3:0] strobes_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strobes_q <= 4'h0;
      seen <= 4'h0;
      wide <= 1'b0;
    end
    else
    begin
      strobes_q <= strobes;
      seen <= seen | strobes;
      wide <= wide | (|(strobes & strobes_q));
    end
  end
endmodule // pwm_ev_partner

// File: tb_pwm_timer_capture_output_events.sv
// self-checking bench for the pwm timer slice over avalon-mm
// assumes one wait state per access and a frozen counter in standby
`timescale 1ns/10ps
module tb_pwm_timer_capture_output_events;
  logic CLK, RESET_N, READ, WRITE, WAITREQUEST;
  logic [5:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA, rd;
  logic [7:0] FUSE_CFG;
  logic [1:0] SLEEP_MODE, fire;
  logic EV_IN_A, EV_IN_B, WO_A, WO_B, EV_COMPARE_B_CLEAR, EV_COMPARE_A_SET;
  logic EV_COMPARE_B_SET, EV_PROG, IRQ_OVF, IRQ_TRIG, wide;
  logic [3:0] seen;
  logic [11:0] v1, v2;
  int mismatches, cmp_count, n;
  logic [7:0] dly_cfg [4] = '{8'h08, 8'h04, 8'h18, 8'h0c};
  int dly_exp [4] = '{2, 0, 4, 0};
  // ============================================================
  // design and partner
  pwm_timer_capture_output_events dut_u (.CLK(CLK), .RESET_N(RESET_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .FUSE_CFG(FUSE_CFG),
    .SLEEP_MODE(SLEEP_MODE), .EV_IN_A(EV_IN_A), .EV_IN_B(EV_IN_B),
    .WO_A(WO_A), .WO_B(WO_B), .EV_COMPARE_B_CLEAR(EV_COMPARE_B_CLEAR),
    .EV_COMPARE_A_SET(EV_COMPARE_A_SET), .EV_COMPARE_B_SET(EV_COMPARE_B_SET), .EV_PROG(EV_PROG),
    .IRQ_OVF(IRQ_OVF), .IRQ_TRIG(IRQ_TRIG));
  pwm_ev_partner partner_u (.clk(CLK), .reset_n(RESET_N), .fire(fire),
    .strobes({EV_PROG, EV_COMPARE_B_SET, EV_COMPARE_A_SET, EV_COMPARE_B_CLEAR}),
    .ev_a(EV_IN_A), .ev_b(EV_IN_B), .seen(seen), .wide(wide));
  // ============================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a,
    input logic [7:0] d);
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= {24'h0, d};
    WRITE <= wr;
    READ <= ~wr;
    do
      @(posedge CLK);
    while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic cap(output logic [11:0] v);
    wr(pwm_pkg::IDX_CMD, 8'h04);
    bus(1'b0, pwm_pkg::IDX_STATUS, 8'h00);
    chk({31'h0, rd[1]}, 32'h0);
    n = 0;
    while (rd[1] !== 1'b1 && n < 20)
    begin
      bus(1'b0, pwm_pkg::IDX_STATUS, 8'h00);
      n++;
    end
    chk({31'h0, rd[1]}, 32'h1);
    bus(1'b0, pwm_pkg::IDX_CAP_A, 8'h00);
    v[7:0] = rd[7:0];
    bus(1'b0, pwm_pkg::IDX_CAP_A + 6'h01, 8'h00);
    v[11:8] = rd[3:0];
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ============================================================
  // clock and watchdog
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial
  begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    wrap_up;
  end
  // ============================================================
  // tests
  initial
  begin
    RESET_N = 1'b0;
    {ADDRESS, READ, WRITE, WRITEDATA, SLEEP_MODE, fire} = '0;
    FUSE_CFG = 8'h21;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    rdchk(pwm_pkg::IDX_FAULT, 32'h21);
    rdchk(6'h3f, 32'h0);
    wr(pwm_pkg::IDX_FAULT, 8'h32);
    rdchk(pwm_pkg::IDX_FAULT, 32'h21);
    wr(pwm_pkg::IDX_PROTECT, pwm_pkg::IO_REGISTER_KEY);
    wr(pwm_pkg::IDX_FAULT, 8'h32);
    rdchk(pwm_pkg::IDX_FAULT, 32'h32);
    wr(pwm_pkg::IDX_BCLR, 8'h10);
    wr(pwm_pkg::IDX_ASET, 8'h04);
    wr(pwm_pkg::IDX_ACLR, 8'h08);
    wr(pwm_pkg::IDX_BSET, 8'h0c);
    wr(pwm_pkg::IDX_CTRL_C, 8'h01);
    wr(pwm_pkg::IDX_CTRL_D, 8'h03);
    wr(pwm_pkg::IDX_IRQ_EN, 8'h01);
    wr(pwm_pkg::IDX_CTRL_A, 8'h01);
    repeat (40) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, WO_A}, 32'h1);
    chk({31'h0, WO_B}, 32'h0);
    chk({30'h0, IRQ_TRIG, IRQ_OVF}, 32'h1);
    rdchk(pwm_pkg::IDX_IRQ_FLAG, 32'h0d);
    wr(pwm_pkg::IDX_IRQ_EN, 8'h09);
    SLEEP_MODE <= pwm_pkg::SLEEP_STANDBY;
    @(negedge CLK);
    chk({31'h0, IRQ_TRIG}, 32'h1);
    wr(pwm_pkg::IDX_IRQ_FLAG, 8'h00);
    rdchk(pwm_pkg::IDX_IRQ_FLAG, 32'h0d);
    wr(pwm_pkg::IDX_IRQ_FLAG, 8'h0d);
    @(negedge CLK);
    chk({30'h0, IRQ_TRIG, IRQ_OVF}, 32'h0);
    repeat (40) @(posedge CLK);
    rdchk(pwm_pkg::IDX_IRQ_FLAG, 32'h0);
    cap(v1);
    cap(v2);
    chk({20'h0, v2}, {20'h0, v1});
    wr(pwm_pkg::IDX_EV_B, 8'h04);
    fire <= 2'h2;
    repeat (4) @(posedge CLK);
    fire <= 2'h0;
    bus(1'b0, pwm_pkg::IDX_CAP_B, 8'h00);
    v2[7:0] = rd[7:0];
    bus(1'b0, pwm_pkg::IDX_CAP_B + 6'h01, 8'h00);
    chk({20'h0, rd[3:0], v2[7:0]}, {20'h0, v1});
    SLEEP_MODE <= 2'h1;
    repeat (40) @(posedge CLK);
    rdchk(pwm_pkg::IDX_IRQ_FLAG, 32'h0d);
    // override off before fault detection, so fault and state levels differ
    wr(pwm_pkg::IDX_CTRL_C, 8'h00);
    wr(pwm_pkg::IDX_IN_B, {4'h0, pwm_pkg::MODE_RESTART});
    fire <= 2'h2;
    @(posedge CLK);
    @(negedge CLK);
    chk({30'h0, EV_IN_B, WO_B}, 32'h3);
    cap(v1);
    chk({31'h0, v1 < 12'h8}, 32'h1);
    fire <= 2'h0;
    // delayed, blanking, prescaled and undelayed events after clear match
    for (int i = 0; i < 4; i++)
    begin
      wr(pwm_pkg::IDX_DLY_VAL, 8'h02);
      wr(pwm_pkg::IDX_DLY_CTRL, dly_cfg[i]);
      n = 0;
      do
      begin
        @(posedge CLK);
        n++;
      end
      while (EV_COMPARE_B_CLEAR !== 1'b1 && n < 60);
      n = 0;
      while (EV_PROG !== 1'b1 && n < 40)
      begin
        @(posedge CLK);
        n++;
      end
      chk(32'(n), 32'(dly_exp[i]));
    end
    repeat (40) @(posedge CLK);
    chk({28'h0, seen}, 32'hf);
    chk({31'h0, wide}, 32'h0);
    wrap_up;
  end
endmodule // tb_pwm_timer_capture_output_events
